// >>> logic/ssp_top.sv
/*
  Synchronous serial port top: register port, spi master and slave, i2c stop,
  interrupt status and mask, sleep freeze and wake.
  Assumes sleep_in comes from core_clk logic; all pins are asynchronous and are
  synchronised here; open-drain lines are resolved outside.
*/
`include "ssp_cfg.svh"

module ssp_top
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // power
  input wire logic sleep_in,
  output logic wake_out,
  output logic irq,
  // spi pins
  input wire logic spi_sclk_in,
  output logic spi_sclk_out,
  output logic spi_sclk_oe_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // i2c pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  function automatic logic mode_is(input logic [7:0] ctrl, input logic [3:0] code);
    mode_is = ctrl[`SSP_C1_EN] & (ctrl[`SSP_C1_MODE_HI:0] == code);
  endfunction

  // pin synchronisers: stage one feeds stage two only
  localparam int NPIN = 4;
  wire [NPIN-1:0] pin_raw = {sda_in, scl_in, spi_sdi, spi_sclk_in};
  logic [NPIN-1:0] pin_s1_q, pin_s2_q;
  // reset to each pin's idle level so no false link edge follows reset
  localparam logic [NPIN-1:0] PIN_IDLE = `SSP_RST_PINS;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          pin_s1_q[gi] <= PIN_IDLE[gi];
          pin_s2_q[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  wire sclk_s = pin_s2_q[0];
  wire sdi_s = pin_s2_q[1];
  wire scl_s = pin_s2_q[2];
  wire sda_s = pin_s2_q[3];

  // registers
  logic [7:0] buf_q, buf_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [7:0] ctrl3_q;
  logic full_q, full_d;
  logic stop_seen_q, stop_seen_d;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_mask_q;
  logic [7:0] baud_q;
  logic [7:0] rdata_q;

  // decode
  wire wr_buf = reg_wr & (reg_addr == `SSP_REG_BUFFER);
  wire wr_c1 = reg_wr & (reg_addr == `SSP_REG_CTRL_ONE);
  wire wr_c3 = reg_wr & (reg_addr == `SSP_REG_CTRL_THREE);
  wire wr_ist = reg_wr & (reg_addr == `SSP_REG_IRQ_STATUS);
  wire wr_msk = reg_wr & (reg_addr == `SSP_REG_IRQ_MASK);
  wire wr_baud = reg_wr & (reg_addr == `SSP_REG_BAUD);
  wire wr_cmd = reg_wr & (reg_addr == `SSP_REG_COMMAND);
  wire rd_buf = reg_rd & (reg_addr == `SSP_REG_BUFFER);

  wire is_spim = mode_is(ctrl1_q, `SSP_MODE_SPI_MASTER);
  wire is_spis = mode_is(ctrl1_q, `SSP_MODE_SPI_SLAVE);
  wire is_i2cm = mode_is(ctrl1_q, `SSP_MODE_I2C_MASTER);

  // spi master engine
  ssp_spim_state_t spim_q, spim_d;
  logic [7:0] mtx_q, mtx_d;
  logic [2:0] mbit_q, mbit_d;
  logic [7:0] mcnt_q, mcnt_d;
  logic msclk_q, msclk_d;
  logic mdone_q, mdone_d;

  wire m_busy = (spim_q != SPIM_IDLE);
  wire m_start = wr_buf & is_spim & ~m_busy;
  wire m_tick = (mcnt_q == 8'h00);

  always_comb
  begin
    spim_d = spim_q;
    mtx_d = mtx_q;
    mbit_d = mbit_q;
    mcnt_d = m_tick ? mcnt_q : mcnt_q - 8'h01;
    msclk_d = msclk_q;
    mdone_d = 1'b0;
    case (spim_q)
      SPIM_IDLE:
        if (m_start)
        begin
          spim_d = SPIM_LOW;
          mtx_d = reg_wdata;
          mbit_d = 3'd0;
          mcnt_d = baud_q;
          msclk_d = 1'b0;
        end
      SPIM_LOW:
        if (m_tick)
        begin
          spim_d = SPIM_HIGH;
          msclk_d = 1'b1;
          mcnt_d = baud_q;
        end
      SPIM_HIGH:
        if (m_tick)
        begin
          msclk_d = 1'b0;
          mcnt_d = baud_q;
          mbit_d = mbit_q + 3'd1;
          mdone_d = (mbit_q == 3'd7);
          spim_d = (mbit_q == 3'd7) ? SPIM_IDLE : SPIM_LOW;
        end
      default:
        spim_d = SPIM_IDLE;
    endcase
    // a disabled port drops the transfer
    if (!is_spim)
    begin
      spim_d = SPIM_IDLE;
      msclk_d = 1'b0;
    end
  end

  // sampled bit kept apart so shift on falling edge sees it
  logic msamp_q;
  wire msamp_d = (spim_q == SPIM_LOW && m_tick) ? sdi_s : msamp_q;
  wire [7:0] mshift = {mtx_q[6:0], msamp_q};

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      spim_q <= SPIM_IDLE;
      mtx_q <= `SSP_RST_BYTE;
      mbit_q <= 3'd0;
      mcnt_q <= 8'h00;
      msclk_q <= 1'b0;
      mdone_q <= 1'b0;
      msamp_q <= 1'b0;
    end
    else if (!sleep_in || !is_spim)
    begin
      spim_q <= spim_d;
      mtx_q <= (spim_q == SPIM_HIGH && m_tick) ? mshift : mtx_d;
      mbit_q <= mbit_d;
      mcnt_q <= mcnt_d;
      msclk_q <= msclk_d;
      mdone_q <= mdone_d;
      msamp_q <= msamp_d;
    end
    else
    begin
      mdone_q <= 1'b0;
    end
  end

  // spi slave
  logic [7:0] s_rx;
  logic s_done;
  logic s_sdo;

  ssp_spi_slave u_slave (
    .core_clk(core_clk),
    .reset(reset),
    .enable(is_spis),
    .tx_load(wr_buf & is_spis),
    .tx_byte(reg_wdata),
    .sclk_s(sclk_s),
    .sdi_s(sdi_s),
    .sdo(s_sdo),
    .rx_byte(s_rx),
    .done(s_done)
  );

  // i2c stop
  logic stop_scl_low, stop_sda_low, stop_busy, stop_done, stop_coll;

  ssp_stop_ctl u_stop (
    .core_clk(core_clk),
    .reset(reset),
    .start(wr_cmd & reg_wdata[`SSP_CMD_STOP] & is_i2cm),
    .reload(baud_q),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_low(stop_scl_low),
    .sda_low(stop_sda_low),
    .busy(stop_busy),
    .done(stop_done),
    .collision(stop_coll)
  );

  // receive buffer and flags
  wire byte_done = mdone_q | s_done;
  wire [7:0] byte_rx = s_done ? s_rx : mtx_q;

  always_comb
  begin
    buf_d = buf_q;
    full_d = full_q & ~rd_buf;
    ctrl1_d = wr_c1 ? reg_wdata : ctrl1_q;
    if (byte_done)
    begin
      buf_d = byte_rx;
      full_d = 1'b1;
      if (full_q && !rd_buf)
      begin
        ctrl1_d[`SSP_C1_OVFL] = 1'b1;
      end
    end
    if (wr_buf && m_busy)
    begin
      ctrl1_d[`SSP_C1_WCOL] = 1'b1;
    end
  end

  // set wins over write-one-to-clear
  wire [1:0] irq_set = {stop_coll, byte_done};
  wire [1:0] irq_clr = wr_ist ? reg_wdata[1:0] : 2'b00;
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_set;
  assign stop_seen_d = (stop_seen_q & ~wr_cmd) | stop_done;

  // read mux
  wire [7:0] state_rd = {3'b000, stop_seen_q, 1'b0, stop_busy, m_busy, full_q};
  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      `SSP_REG_BUFFER: rd_mux = buf_q;
      `SSP_REG_CTRL_ONE: rd_mux = ctrl1_q;
      `SSP_REG_CTRL_THREE: rd_mux = ctrl3_q;
      `SSP_REG_STATE: rd_mux = state_rd;
      `SSP_REG_IRQ_STATUS: rd_mux = {6'b00_0000, irq_st_q};
      `SSP_REG_IRQ_MASK: rd_mux = {6'b00_0000, irq_mask_q};
      `SSP_REG_BAUD: rd_mux = baud_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // pins and power outputs
  wire irq_d = |(irq_st_d & irq_mask_q);
  wire wake_d = sleep_in & irq_st_d[`SSP_IRQ_PORT] & irq_mask_q[`SSP_IRQ_PORT];
  wire sdo_d = is_spis ? s_sdo : mtx_q[7];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      buf_q <= `SSP_RST_BYTE;
      ctrl1_q <= `SSP_RST_BYTE;
      ctrl3_q <= `SSP_RST_BYTE;
      full_q <= 1'b0;
      stop_seen_q <= 1'b0;
      irq_st_q <= 2'b00;
      irq_mask_q <= 2'b00;
      baud_q <= `SSP_RST_BAUD;
      rdata_q <= 8'h00;
    end
    else
    begin
      buf_q <= buf_d;
      ctrl1_q <= ctrl1_d;
      ctrl3_q <= wr_c3 ? reg_wdata : ctrl3_q;
      full_q <= full_d;
      stop_seen_q <= stop_seen_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= wr_msk ? reg_wdata[1:0] : irq_mask_q;
      baud_q <= wr_baud ? reg_wdata : baud_q;
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  logic irq_q, wake_q, sdo_q, sclk_out_q, sclk_oe_n_q, scl_oe_n_q, sda_oe_n_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      sdo_q <= 1'b0;
      sclk_out_q <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      irq_q <= irq_d;
      wake_q <= wake_d;
      sdo_q <= sdo_d;
      sclk_out_q <= msclk_q;
      sclk_oe_n_q <= ~is_spim;
      scl_oe_n_q <= ~(stop_scl_low & is_i2cm);
      sda_oe_n_q <= ~(stop_sda_low & is_i2cm);
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign wake_out = wake_q;
  assign spi_sdo = sdo_q;
  assign spi_sclk_out = sclk_out_q;
  assign spi_sclk_oe_n = sclk_oe_n_q;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_oe_n = sda_oe_n_q;

endmodule // ssp_top

// >>> logic/ssp_cfg.svh
/*
  Constants of the serial port: register offsets, field positions, reset values, mode codes.
  Assumes a byte-wide register port with a 3-bit word index and one core clock.
*/
// Behaviour
// - spi master: sleep freezes the shift engine, every bit of state held except the mdone_q pulse, which clears.
// - spi master: after wake the frozen transfer resumes where it stopped.
// - spi slave: shifting follows only the incoming serial clock, also in sleep.
// - spi slave: a full eight-bit byte sets the interrupt flag, waking when enabled.
// - no wake from sleep while the port interrupt enable is clear.
// - stop: drive data low first, release clock only after data reads low.
// - stop: clock seen high, load baud counter from reload, count to 0, release data, reload, count to 0, sample data.
// - stop: released data read low at counter expiry declares a bus collision.
// - stop: released clock read low before data rises declares a bus collision.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// register indices
`define SSP_REG_BUFFER 3'h0
`define SSP_REG_CTRL_ONE 3'h1
`define SSP_REG_CTRL_THREE 3'h2
`define SSP_REG_STATE 3'h3
`define SSP_REG_IRQ_STATUS 3'h4
`define SSP_REG_IRQ_MASK 3'h5
`define SSP_REG_BAUD 3'h6
`define SSP_REG_COMMAND 3'h7

// serial_control_one fields
`define SSP_C1_WCOL 7
`define SSP_C1_OVFL 6
`define SSP_C1_EN 5
`define SSP_C1_MODE_HI 3
`define SSP_MODE_SPI_MASTER 4'h0
`define SSP_MODE_SPI_SLAVE 4'h4
`define SSP_MODE_I2C_MASTER 4'h8

// serial_port_state fields
`define SSP_ST_FULL 0
`define SSP_ST_SPI_BUSY 1
`define SSP_ST_STOP_BUSY 2
`define SSP_ST_STOP_SEEN 4

// interrupt status and mask fields
`define SSP_IRQ_PORT 0
`define SSP_IRQ_BCOL 1

// command register
`define SSP_CMD_STOP 0

// reset values
`define SSP_RST_BYTE 8'h00
`define SSP_RST_BAUD 8'h04
// synchroniser reset: {sda, scl, sdi, sclk}
`define SSP_RST_PINS 4'hc

`endif

// >>> logic/ssp_pkg.sv
/*
  Types of the serial port: state machine enumerations.
  Assumes ssp_cfg.svh for all numeric constants.
*/
package ssp_pkg;

  typedef enum logic [1:0] {SPIM_IDLE, SPIM_LOW, SPIM_HIGH} ssp_spim_state_t;

  typedef enum logic [2:0] {
    STOP_IDLE, STOP_SDA_LOW, STOP_SCL_REL, STOP_SCL_HOLD, STOP_SDA_REL
  } ssp_stop_state_t;

endpackage

// >>> logic/ssp_spi_slave.sv
/*
  Spi slave shifter, mode 0: samples on rising, shifts out on falling serial clock.
  Assumes sclk_s and sdi_s already synchronised to core_clk.
*/
`include "ssp_cfg.svh"

module ssp_spi_slave
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic enable,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  // link
  input wire logic sclk_s,
  input wire logic sdi_s,
  output logic sdo,
  // result
  output logic [7:0] rx_byte,
  output logic done
);

  logic sclk_prev_q;
  logic [7:0] shift_q, shift_d;
  logic [2:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic out_q, out_d;
  wire rise = enable & sclk_s & ~sclk_prev_q;
  wire fall = enable & ~sclk_s & sclk_prev_q;

  // no dependence on sleep: only link edges move the shifter
  always_comb
  begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    out_d = out_q;
    if (tx_load)
    begin
      shift_d = tx_byte;
      out_d = tx_byte[7];
    end
    else if (rise)
    begin
      shift_d = {shift_q[6:0], sdi_s};
      cnt_d = cnt_q + 3'd1;
      done_d = (cnt_q == 3'd7);
    end
    else if (fall)
    begin
      // next bit already moved up by the rising edge
      out_d = shift_q[7];
    end
    if (!enable)
    begin
      cnt_d = 3'd0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sclk_prev_q <= 1'b0;
      shift_q <= `SSP_RST_BYTE;
      cnt_q <= 3'd0;
      done_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      out_q <= out_d;
    end
  end

  assign sdo = out_q;
  assign rx_byte = shift_q;
  assign done = done_q;

endmodule // ssp_spi_slave

// >>> logic/ssp_stop_ctl.sv
/*
  I2c master stop sequence with bus-collision detection.
  Assumes scl_s and sda_s synchronised; drive outputs pull a line low when high.
*/
`include "ssp_cfg.svh"

module ssp_stop_ctl
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request
  input wire logic start,
  input wire logic [7:0] reload,
  // bus lines
  input wire logic scl_s,
  input wire logic sda_s,
  output logic scl_low,
  output logic sda_low,
  // result
  output logic busy,
  output logic done,
  output logic collision
);

  ssp_stop_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic done_d, coll_d, done_q, coll_q;
  wire expired = (cnt_q == 8'h00);

  always_comb
  begin
    state_d = state_q;
    cnt_d = expired ? cnt_q : cnt_q - 8'h01;
    done_d = 1'b0;
    coll_d = 1'b0;
    case (state_q)
      STOP_IDLE:
        if (start)
        begin
          state_d = STOP_SDA_LOW;
        end
      STOP_SDA_LOW:
        if (!sda_s)
        begin
          state_d = STOP_SCL_REL;
        end
      STOP_SCL_REL:
        if (scl_s)
        begin
          state_d = STOP_SCL_HOLD;
          cnt_d = reload;
        end
      STOP_SCL_HOLD:
        if (!scl_s)
        begin
          state_d = STOP_IDLE;
          coll_d = 1'b1;
        end
        else if (expired)
        begin
          state_d = STOP_SDA_REL;
          cnt_d = reload;
        end
      STOP_SDA_REL:
        if (!scl_s)
        begin
          state_d = STOP_IDLE;
          coll_d = 1'b1;
        end
        else if (expired)
        begin
          state_d = STOP_IDLE;
          coll_d = ~sda_s;
          done_d = sda_s;
        end
      default:
        state_d = STOP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= STOP_IDLE;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
      coll_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      coll_q <= coll_d;
    end
  end

  // clock held low until data is low, data held low until its own release step
  assign scl_low = (state_q == STOP_SDA_LOW);
  assign sda_low = (state_q == STOP_SDA_LOW) | (state_q == STOP_SCL_REL) |
                   (state_q == STOP_SCL_HOLD);
  assign busy = (state_q != STOP_IDLE);
  assign done = done_q;
  assign collision = coll_q;

endmodule // ssp_stop_ctl

// >>> sim/ssp_chk.sv
/*
  Checker of ssp_top port timing: reads, sleep freeze, wake, irq, stop release.
  Assumes binding into ssp_top; the irq mask is tracked from port writes.
*/
`include "ssp_cfg.svh"

module ssp_chk
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // power and pins
  input wire logic sleep_in,
  input wire logic wake_out,
  input wire logic irq,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe_n,
  input wire logic spi_sdo,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  wire logic mask_wr = reg_wr && (reg_addr == `SSP_REG_IRQ_MASK);
  assign mask_d = mask_wr ? reg_wdata[1:0] : mask_q;
  always_ff @(posedge core_clk)
    mask_q <= reset ? 2'h0 : mask_d;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read slot");
  property p_freeze;
    sleep_in && !spi_sclk_oe_n |=> $stable(spi_sclk_out) && $stable(spi_sdo);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("spi master moved while asleep");
  // half period is at most 256 cycles
  property p_resume;
    spi_sclk_out && !sleep_in |-> ##[1:257] (!spi_sclk_out || sleep_in);
  endproperty
  a_resume: assert property (p_resume)
    else $error("spi master clock stuck while awake");
  property p_wake_sleep;
    wake_out |-> $past(sleep_in);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("wake outside sleep");
  property p_wake_en;
    wake_out |-> $past(mask_q[`SSP_IRQ_PORT]);
  endproperty
  a_wake_en: assert property (p_wake_en)
    else $error("wake with port interrupt disabled");
  property p_irq_mask;
    irq |-> ($past(mask_q) | mask_q) != 2'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with every source masked");
  property p_scl_after_sda;
    $rose(scl_oe_n) && !sda_oe_n |-> $past(sda_oe_n, 2) == 1'h0;
  endproperty
  a_scl_after_sda: assert property (p_scl_after_sda)
    else $error("clock released before data was low");
  property p_both_rel;
    $rose(sda_oe_n) |-> scl_oe_n;
  endproperty
  a_both_rel: assert property (p_both_rel)
    else $error("data released while clock held");

  c_wake: cover property (wake_out);
  c_freeze: cover property (sleep_in && !spi_sclk_oe_n);
  c_stop: cover property ($rose(sda_oe_n));
endmodule // ssp_chk

bind ssp_top ssp_chk i_chk (
  .core_clk(core_clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .sleep_in(sleep_in),
  .wake_out(wake_out),
  .irq(irq),
  .spi_sclk_out(spi_sclk_out),
  .spi_sclk_oe_n(spi_sclk_oe_n),
  .spi_sdo(spi_sdo),
  .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n)
);

// >>> sim/ssp_peer.sv
/*
  Far side: spi master or slave facing the port, and a rival i2c master.
  Assumes pull-ups on both i2c lines; the bench steers pulls and frames.
*/
module ssp_peer
(
  // spi
  input wire logic spi_sclk_out,
  input wire logic spi_sdo,
  output logic spi_sclk_in,
  output logic spi_sdi,
  // i2c
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic pull_scl,
  input wire logic pull_sda,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sr = 8'h00;
  logic [7:0] rx = 8'h00;
  logic m_on = 1'h0;
  logic m_bit = 1'h0;
  // wired and: low while either party pulls
  assign scl_in = scl_oe_n & ~pull_scl;
  assign sda_in = sda_oe_n & ~pull_sda;
  assign spi_sdi = m_on ? m_bit : sr[7];
  initial spi_sclk_in = 1'h0;
  // slave role; bits past the byte come out inverted, never stale
  always @(negedge spi_sclk_out) sr <= {sr[6:0], ~sr[7]};
  always @(posedge spi_sclk_out) rx <= {rx[6:0], spi_sdo};
  task automatic load(input logic [7:0] b);
    m_on = 1'h0;
    sr = b;
  endtask
  // master role, mode 0; clock rests low between frames
  task automatic send(input logic [7:0] b);
    m_on = 1'h1;
    for (int i = 7; i >= 0; i--)
    begin
      m_bit = b[i];
      #62.5 spi_sclk_in = 1'h1;
      #62.5 spi_sclk_in = 1'h0;
    end
    m_bit = ~b[0];
  endtask
endmodule // ssp_peer

// >>> sim/ssp_top_tb.sv
/*
  Bench of ssp_top: register tasks, spi sleep and wake, stop and collisions.
  Assumes ssp_peer on the far side and the bound checker.
*/
`include "ssp_cfg.svh"

module ssp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic sleep_in = 1'h0;
  logic pull_scl = 1'h0;
  logic pull_sda = 1'h0;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic wake_out, irq, spi_sclk_in, spi_sclk_out, spi_sclk_oe_n, spi_sdi, spi_sdo;
  logic scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n;
  int n_fail = 0;
  int num_checks = 0;

  ssp_top i_dut (
    .core_clk(core_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sleep_in(sleep_in),
    .wake_out(wake_out),
    .irq(irq),
    .spi_sclk_in(spi_sclk_in),
    .spi_sclk_out(spi_sclk_out),
    .spi_sclk_oe_n(spi_sclk_oe_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n)
  );
  ssp_peer i_peer (
    .spi_sclk_out(spi_sclk_out),
    .spi_sdo(spi_sdo),
    .spi_sclk_in(spi_sclk_in),
    .spi_sdi(spi_sdi),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n),
    .pull_scl(pull_scl),
    .pull_sda(pull_sda),
    .scl_in(scl_in),
    .sda_in(sda_in)
  );

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic poll(input int b);
    int i;
    for (i = 0; i < 300; i++)
    begin
      rd(`SSP_REG_STATE, d);
      if (d[b] === 1'h0) break;
    end
    if (i == 300)
    begin
      n_fail++;
      $display("Error %0t: busy bit never cleared", $time);
    end
    cyc(3);
  endtask
  // wait until data is held low and clock has been let go
  task automatic wscl;
    int i;
    for (i = 0; i < 60; i++)
    begin
      @(negedge core_clk);
      if (scl_oe_n === 1'h1 && sda_oe_n === 1'h0) break;
    end
    if (i == 60)
    begin
      n_fail++;
      $display("Error %0t: clock release not seen", $time);
    end
    @(posedge core_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #300us;
    n_fail++;
    $display("Error %0t: timeout", $time);
    stop_test();
  end

  initial
  begin
    cyc(2);
    reset <= 1'h0;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), d);
      chk8(d, (a == 6) ? `SSP_RST_BAUD : `SSP_RST_BYTE);
    end
    $display("test 1 done");
    // master transfer frozen by sleep midway
    wr(`SSP_REG_BAUD, 8'h03);
    wr(`SSP_REG_CTRL_ONE, 8'h20);
    wr(`SSP_REG_IRQ_MASK, 8'h01);
    i_peer.load(8'h3C);
    wr(`SSP_REG_BUFFER, 8'hA5);
    cyc(20);
    @(posedge core_clk) sleep_in <= 1'h1;
    cyc(2);
    #1 d = {6'h00, spi_sclk_out, spi_sdo};
    cyc(80);
    #1 chk8({6'h00, spi_sclk_out, spi_sdo}, d);
    rd(`SSP_REG_STATE, d);
    chk8(d, 8'h02);
    @(posedge core_clk) sleep_in <= 1'h0;
    poll(`SSP_ST_SPI_BUSY);
    rd(`SSP_REG_BUFFER, d);
    chk8(d, 8'h3C);
    chk8(i_peer.rx, 8'hA5);
    chk8({7'h00, irq}, 8'h01);
    wr(`SSP_REG_IRQ_STATUS, 8'h01);
    cyc(2);
    #1 chk8({7'h00, irq}, 8'h00);
    $display("test 2 done");
    // slave bytes in sleep, port interrupt enabled then disabled
    wr(`SSP_REG_CTRL_ONE, 8'h24);
    for (int k = 0; k < 2; k++)
    begin
      wr(`SSP_REG_IRQ_MASK, k ? 8'h00 : 8'h01);
      @(posedge core_clk) sleep_in <= 1'h1;
      i_peer.send(k ? 8'h5A : 8'h96);
      cyc(8);
      #1 chk8({6'h00, wake_out, irq}, k ? 8'h00 : 8'h03);
      @(posedge core_clk) sleep_in <= 1'h0;
      rd(`SSP_REG_IRQ_STATUS, d);
      chk8(d, 8'h01);
      rd(`SSP_REG_BUFFER, d);
      chk8(d, k ? 8'h5A : 8'h96);
      wr(`SSP_REG_IRQ_STATUS, 8'h01);
    end
    $display("test 3 done");
    // stop with the clock stretched by the rival
    wr(`SSP_REG_CTRL_ONE, 8'h28);
    wr(`SSP_REG_BAUD, 8'h10);
    wr(`SSP_REG_IRQ_MASK, 8'h02);
    @(posedge core_clk) pull_scl <= 1'h1;
    wr(`SSP_REG_COMMAND, 8'h01);
    wscl();
    cyc(20);
    pull_scl <= 1'h0;
    poll(`SSP_ST_STOP_BUSY);
    rd(`SSP_REG_STATE, d);
    chk8(d, 8'h10);
    rd(`SSP_REG_IRQ_STATUS, d);
    chk8(d, 8'h00);
    $display("test 4 done");
    // rival holds data low, then pulls clock low early
    for (int k = 0; k < 2; k++)
    begin
      wr(`SSP_REG_COMMAND, 8'h01);
      wscl();
      if (k == 0)
        pull_sda <= 1'h1;
      else
      begin
        cyc(6);
        pull_scl <= 1'h1;
        cyc(4);
        pull_scl <= 1'h0;
      end
      poll(`SSP_ST_STOP_BUSY);
      rd(`SSP_REG_IRQ_STATUS, d);
      chk8(d, 8'h02);
      rd(`SSP_REG_STATE, d);
      chk8(d, 8'h00);
      chk8({5'h00, irq, scl_oe_n, sda_oe_n}, 8'h07);
      @(posedge core_clk) pull_sda <= 1'h0;
      wr(`SSP_REG_IRQ_STATUS, 8'h02);
      cyc(2);
      #1 chk8({7'h00, irq}, 8'h00);
    end
    $display("test 5 done");
    stop_test();
  end
endmodule // ssp_top_tb
